// ### rtl/rdiu_pkg.sv
// Shared constants and types of the repeat divide and increment/decrement unit
package rdiu_pkg;
  localparam int          RDIU_WORD_W   = 16;
  localparam int          RDIU_LONG_W   = 32;
  localparam int          RDIU_NUM_W    = 48;
  localparam int          RDIU_DIV_STEPS = 48;
  localparam logic [5:0]  RDIU_LAST_STEP = 6'd47;
  localparam logic        RDIU_FLAG_RST = 1'b0;
  localparam logic [9:0]  RDIU_FLT_BIAS = 10'h07F;
  localparam logic [7:0]  RDIU_FLT_EMAX = 8'hFF;
  localparam logic [31:0] RDIU_FLT_INF  = 32'h7F800000;

  typedef enum logic [1:0] {
    RDIU_OP_DIV,
    RDIU_OP_INC,
    RDIU_OP_DEC
  } rdiu_op_t;

  typedef enum logic [2:0] {
    RDIU_DT_WORD,
    RDIU_DT_INT,
    RDIU_DT_DWORD,
    RDIU_DT_LONG,
    RDIU_DT_FLOAT
  } rdiu_dtype_t;
endpackage

// ### rtl/rdiu_div_if.sv
// Request and answer signals between the sequencer and the iterative divider
`timescale 1ns/10ps
`default_nettype none
interface rdiu_div_if;
  logic        start;
  logic [47:0] num;
  logic [31:0] den;
  logic        done;
  logic [47:0] quo;
  logic [31:0] rem;
  modport master (output start, output num, output den, input done, input quo, input rem);
  modport slave  (input start, input num, input den, output done, output quo, output rem);
endinterface
`default_nettype wire

// ### rtl/rdiu_divider.sv
// Restoring divider: one quotient bit per clock, 48 steps
`timescale 1ns/10ps
`default_nettype none
module rdiu_divider
  import rdiu_pkg::*;
(
  input wire logic   clk_i,
  input wire logic   rst_b_i,
  rdiu_div_if.slave  div
);
  logic [47:0] quo;
  logic [32:0] rem;
  logic [5:0]  step;
  logic        run;
  logic        done;
  logic [32:0] trial;

  assign trial    = {rem[31:0], quo[47]};
  assign div.quo  = quo;
  assign div.rem  = rem[31:0];
  assign div.done = done;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      quo  <= '0;
      rem  <= '0;
      step <= '0;
      run  <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (div.start) begin
        quo  <= div.num;
        rem  <= '0;
        step <= '0;
        run  <= 1'b1;
      end else if (run) begin
        if (trial >= {1'b0, div.den}) begin
          rem <= trial - {1'b0, div.den};
          quo <= {quo[46:0], 1'b1};
        end else begin
          rem <= trial;
          quo <= {quo[46:0], 1'b0};
        end
        step <= step + 6'd1;
        if (step == RDIU_LAST_STEP) begin
          run  <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/rdiu_unit.sv
// Data register file with repeated divide and increment/decrement execution
// How it works
// - Word/integer divide, fixed target: quotient at target, remainder next; last pass stays.
// - Double/long divide, fixed target: quotient pair, then remainder pair; last pass stays.
// - Float divide, fixed target: one quotient pair, no remainder; last pass stays.
// - Word/integer, repeated target: quotients consecutive, remainders right after them.
// - Double/long, repeated target: quotient pairs consecutive, remainder pairs after them.
// - Float, repeated target: one quotient pair per pass, consecutive, no remainders.
// - Repeated first source and target: each pass takes next source, own slot.
// - All repeated: both sources and target slot advance every pass.
// - Any pass error sets error flag and indicator, held; other work continues.
// - Increment adds one to 16- or 32-bit operand, written back in place.
// - Decrement subtracts one from 16- or 32-bit operand, written back in place.
// - Increment/decrement repeats on every execution request while the input stays on.
// - Increment at maximum wraps to zero and sets carry/borrow flag.
// - Decrement at minimum gives all ones (max or -1) and sets carry/borrow.
// - Increment/decrement take word, integer, double, long; one or two registers.
// - Repeated operand walks consecutive registers; unrepeated operand reused each pass.
// - Float divide gives no remainder; quotient held in two consecutive registers.
`timescale 1ns/10ps
`default_nettype none
module rdiu_unit #(
  parameter int ADDR_W = 10,
  parameter int REP_W  = 5
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_b_i,
  input  wire logic                     start_i,
  input  wire rdiu_pkg::rdiu_op_t       op_i,
  input  wire rdiu_pkg::rdiu_dtype_t    dtype_i,
  input  wire logic [ADDR_W-1:0]        first_source_i,
  input  wire logic [ADDR_W-1:0]        second_source_i,
  input  wire logic [ADDR_W-1:0]        result_target_i,
  input  wire logic [REP_W-1:0]         repeat_cycles_i,
  input  wire logic                     first_source_rep_i,
  input  wire logic                     second_source_rep_i,
  input  wire logic                     result_target_rep_i,
  input  wire logic                     host_we_i,
  input  wire logic [ADDR_W-1:0]        host_addr_i,
  input  wire logic [15:0]              host_wdata_i,
  input  wire logic [ADDR_W-1:0]        host_raddr_i,
  input  wire logic                     flag_clear_i,
  output logic [15:0]                   host_rdata_o,
  output logic                          busy_o,
  output logic                          done_o,
  output logic                          carry_borrow_flag_o,
  output logic                          exec_error_flag_o,
  output logic                          err_led_o
);
  import rdiu_pkg::*;

  if (ADDR_W < 4 || ADDR_W > 16 || REP_W < 1 || REP_W > 8) begin : g_bad_param
    $error("rdiu_unit: ADDR_W must be 4..16 and REP_W 1..8");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_DIV, ST_WQ, ST_WR, ST_NEXT} rdiu_state_t;

  logic [15:0]       mem [2**ADDR_W];
  rdiu_state_t       state;
  rdiu_op_t          op;
  rdiu_dtype_t       dt;
  logic [ADDR_W-1:0] s1, s2, dst;
  logic [REP_W-1:0]  passes, pass;
  logic              s1_rep, s2_rep, dst_rep;
  logic              neg_q, neg_r, f_sign;
  logic signed [9:0] f_exp;
  logic [31:0]       q_res, r_res;
  logic              err_flag, carry_flag;
  logic              set_err, set_carry;
  logic              wide, sgn;
  logic [31:0]       opa, opb, mag_a, mag_b, upd, max_v, min_v;
  logic [ADDR_W-1:0] q_addr, r_addr;
  logic              eng_we;
  logic [ADDR_W-1:0] eng_addr;
  logic [31:0]       eng_data;
  logic [24:0]       fq;
  logic signed [9:0] fe;

  rdiu_div_if div_if ();

  rdiu_divider u_div (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .div     (div_if)
  );

  // Operand fetch: 32-bit values keep the upper word at the lower address
  function automatic logic [31:0] fetch(input logic [ADDR_W-1:0] a, input logic w,
                                        input logic s);
    logic [ADDR_W-1:0] a1;
    a1 = a + ADDR_W'(1);
    if (w)
      fetch = {mem[a], mem[a1]};
    else if (s)
      fetch = {{16{mem[a][15]}}, mem[a]};
    else
      fetch = {16'h0000, mem[a]};
  endfunction

  // Slot address: repeated operands walk by one or two registers per pass
  function automatic logic [ADDR_W-1:0] slot(input logic [ADDR_W-1:0] base,
                                             input logic [REP_W-1:0] k, input logic rep,
                                             input logic w);
    logic [ADDR_W+REP_W:0] off;
    off  = rep ? ((ADDR_W+REP_W+1)'(k) << w) : '0;
    slot = base + off[ADDR_W-1:0];
  endfunction

  always_comb begin
    wide  = dt inside {RDIU_DT_DWORD, RDIU_DT_LONG, RDIU_DT_FLOAT};
    sgn   = dt inside {RDIU_DT_INT, RDIU_DT_LONG};
    opa   = fetch(op == RDIU_OP_DIV ? slot(s1, pass, s1_rep, wide) : dst, wide, sgn);
    opb   = fetch(slot(s2, pass, s2_rep, wide), wide, sgn);
    mag_a = (sgn && opa[31]) ? 32'h0 - opa : opa;
    mag_b = (sgn && opb[31]) ? 32'h0 - opb : opb;
    max_v = wide ? (sgn ? 32'h7FFFFFFF : 32'hFFFFFFFF) : (sgn ? 32'h00007FFF : 32'h0000FFFF);
    min_v = sgn ? (wide ? 32'h80000000 : 32'hFFFF8000) : 32'h00000000;
    if (op == RDIU_OP_INC)
      upd = (opa == max_v) ? 32'h0 : opa + 32'h1;
    else
      upd = (opa == min_v) ? 32'hFFFFFFFF : opa - 32'h1;
  end

  // Quotient slots first, remainder block after all of them when the target repeats
  always_comb begin
    q_addr = slot(dst, pass, dst_rep, wide);
    r_addr = q_addr + (wide ? ADDR_W'(2) : ADDR_W'(1));
    if (dst_rep)
      r_addr = q_addr + ADDR_W'((ADDR_W+REP_W+1)'(passes) << wide);
  end

  always_comb begin
    eng_we   = 1'b0;
    eng_addr = dst;
    eng_data = upd;
    unique case (state)
      // A float operand is refused by increment/decrement and stays untouched
      ST_LOAD: eng_we = op != RDIU_OP_DIV && dt != RDIU_DT_FLOAT;
      ST_WQ: begin
        eng_we   = 1'b1;
        eng_addr = q_addr;
        eng_data = q_res;
      end
      ST_WR: begin
        eng_we   = 1'b1;
        eng_addr = r_addr;
        eng_data = r_res;
      end
      ST_IDLE, ST_DIV, ST_NEXT: eng_we = 1'b0;
      default: eng_we = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (eng_we) begin
      if (wide) begin
        mem[eng_addr]                <= eng_data[31:16];
        mem[eng_addr + ADDR_W'(1)]   <= eng_data[15:0];
      end else begin
        mem[eng_addr] <= eng_data[15:0];
      end
    end else if (host_we_i && state == ST_IDLE) begin
      mem[host_addr_i] <= host_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      host_rdata_o <= '0;
    else
      host_rdata_o <= mem[host_raddr_i];
  end

  // Float result normalisation from the 25-bit quotient of the mantissas
  always_comb begin
    fq = div_if.quo[24:0];
    // A mantissa ratio below one lands one bit lower, so the exponent drops by one
    fe = fq[24] ? f_exp : f_exp - 10'sd1;
  end

  assign div_if.num = (dt == RDIU_DT_FLOAT) ? {1'b1, opa[22:0], 24'h0} : {16'h0, mag_a};
  assign div_if.den = (dt == RDIU_DT_FLOAT) ? {8'h00, 1'b1, opb[22:0]} : mag_b;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state        <= ST_IDLE;
      op           <= RDIU_OP_DIV;
      dt           <= RDIU_DT_WORD;
      s1           <= '0;
      s2           <= '0;
      dst          <= '0;
      passes       <= '0;
      pass         <= '0;
      s1_rep       <= 1'b0;
      s2_rep       <= 1'b0;
      dst_rep      <= 1'b0;
      neg_q        <= 1'b0;
      neg_r        <= 1'b0;
      f_sign       <= 1'b0;
      f_exp        <= '0;
      q_res        <= '0;
      r_res        <= '0;
      set_err      <= 1'b0;
      set_carry    <= 1'b0;
      div_if.start <= 1'b0;
      busy_o       <= 1'b0;
      done_o       <= 1'b0;
    end else begin
      div_if.start <= 1'b0;
      done_o       <= 1'b0;
      set_err      <= 1'b0;
      set_carry    <= 1'b0;
      unique case (state)
        ST_IDLE: if (start_i) begin
          op      <= op_i;
          dt      <= dtype_i;
          s1      <= first_source_i;
          s2      <= second_source_i;
          dst     <= result_target_i;
          // Increment/decrement never repeats; the operand is the target register
          passes  <= (repeat_cycles_i == '0 || op_i != RDIU_OP_DIV) ? REP_W'(1) : repeat_cycles_i;
          s1_rep  <= first_source_rep_i;
          s2_rep  <= second_source_rep_i;
          dst_rep <= result_target_rep_i;
          pass    <= '0;
          busy_o  <= 1'b1;
          state   <= ST_LOAD;
        end
        ST_LOAD: begin
          if (op != RDIU_OP_DIV) begin
            // Float is not a legal increment/decrement type
            set_err   <= dt == RDIU_DT_FLOAT;
            set_carry <= dt != RDIU_DT_FLOAT && opa == (op == RDIU_OP_INC ? max_v : min_v);
            busy_o    <= 1'b0;
            done_o    <= 1'b1;
            state     <= ST_IDLE;
          end else if (dt == RDIU_DT_FLOAT) begin
            f_sign <= opa[31] ^ opb[31];
            f_exp  <= $signed({2'b00, opa[30:23]}) - $signed({2'b00, opb[30:23]})
                      + $signed(RDIU_FLT_BIAS);
            if (opb[30:23] == 8'h00 || opb[30:23] == RDIU_FLT_EMAX
                || opa[30:23] == RDIU_FLT_EMAX) begin
              set_err <= 1'b1;
              state   <= ST_NEXT;
            end else if (opa[30:0] == 31'h0) begin
              q_res <= 32'h0;
              state <= ST_WQ;
            end else if (opa[30:23] == 8'h00) begin
              set_err <= 1'b1;
              state   <= ST_NEXT;
            end else begin
              div_if.start <= 1'b1;
              state        <= ST_DIV;
            end
          end else if (opb == 32'h0) begin
            set_err <= 1'b1;
            state   <= ST_NEXT;
          end else begin
            neg_q        <= sgn && (opa[31] ^ opb[31]);
            neg_r        <= sgn && opa[31];
            div_if.start <= 1'b1;
            state        <= ST_DIV;
          end
        end
        ST_DIV: if (div_if.done) begin
          if (dt == RDIU_DT_FLOAT) begin
            if (fe >= 10'sd255) begin
              q_res     <= RDIU_FLT_INF | {f_sign, 31'h0};
              set_carry <= 1'b1;
            end else if (fe <= 10'sd0) begin
              q_res     <= {f_sign, 31'h0};
              set_carry <= 1'b1;
            end else begin
              q_res <= {f_sign, fe[7:0], fq[24] ? fq[23:1] : fq[22:0]};
            end
          end else begin
            q_res <= neg_q ? 32'h0 - div_if.quo[31:0] : div_if.quo[31:0];
            r_res <= neg_r ? 32'h0 - div_if.rem : div_if.rem;
            // Only the most negative value divided by -1 leaves the signed range
            set_carry <= sgn && !neg_q && (wide ? div_if.quo[31] : div_if.quo[15]);
          end
          state <= ST_WQ;
        end
        ST_WQ: state <= (dt == RDIU_DT_FLOAT) ? ST_NEXT : ST_WR;
        ST_WR: state <= ST_NEXT;
        ST_NEXT: begin
          // An unrepeated target is simply overwritten, so the last pass remains
          if (pass == passes - REP_W'(1)) begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
            state  <= ST_IDLE;
          end else begin
            pass  <= pass + REP_W'(1);
            state <= ST_LOAD;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Sticky flags; a new event wins over a clear in the same cycle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      err_flag   <= RDIU_FLAG_RST;
      carry_flag <= RDIU_FLAG_RST;
    end else begin
      err_flag   <= set_err | (err_flag & ~flag_clear_i);
      carry_flag <= set_carry | (carry_flag & ~flag_clear_i);
    end
  end

  assign exec_error_flag_o   = err_flag;
  assign err_led_o           = err_flag;
  assign carry_borrow_flag_o = carry_flag;
endmodule
`default_nettype wire

// ### verif/rdiu_unit_properties.sv
// Concurrent checks of the execution handshake and the sticky flags
`timescale 1ns/10ps
`default_nettype none
module rdiu_unit_chk
  import rdiu_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic        start_i,
  input wire rdiu_op_t    op_i,
  input wire rdiu_dtype_t dtype_i,
  input wire logic        flag_clear_i,
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic        carry_borrow_flag_o,
  input wire logic        exec_error_flag_o,
  input wire logic        err_led_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_incdec_len;
    start_i && !busy_o && op_i != RDIU_OP_DIV && dtype_i != RDIU_DT_FLOAT
      |=> busy_o && !done_o ##1 !busy_o && done_o;
  endproperty
  a_incdec_len: assert property (p_incdec_len) else $error("inc/dec not done in two edges");
  // Even an error pass spends a load and a step cycle
  property p_div_busy;
    start_i && !busy_o && op_i == RDIU_OP_DIV |=> busy_o[*2];
  endproperty
  a_div_busy: assert property (p_div_busy) else $error("divide finished too early");
  property p_done_pulse;
    done_o |-> !busy_o && $past(busy_o) ##1 !done_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done pulse malformed");
  property p_busy_cause;
    $rose(busy_o) |-> $past(start_i);
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without start");
  property p_err_hold;
    exec_error_flag_o && !flag_clear_i |=> exec_error_flag_o;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag not held");
  property p_led;
    err_led_o == exec_error_flag_o;
  endproperty
  a_led: assert property (p_led) else $error("indicator differs from error flag");
  property p_carry_hold;
    carry_borrow_flag_o && !flag_clear_i |=> carry_borrow_flag_o;
  endproperty
  a_carry_hold: assert property (p_carry_hold) else $error("carry flag not held");
  property p_err_rise;
    $rose(exec_error_flag_o) |-> $past(busy_o, 2);
  endproperty
  a_err_rise: assert property (p_err_rise) else $error("error flag set while idle");
  property p_carry_rise;
    $rose(carry_borrow_flag_o) |-> $past(busy_o, 2);
  endproperty
  a_carry_rise: assert property (p_carry_rise) else $error("carry set while idle");
  property p_clear_idle;
    flag_clear_i && !busy_o && !done_o |=> !exec_error_flag_o && !carry_borrow_flag_o;
  endproperty
  a_clear_idle: assert property (p_clear_idle) else $error("flags survive clear");

  c_incdec: cover property (start_i && !busy_o && op_i == RDIU_OP_INC);
  c_wrap:   cover property ($rose(carry_borrow_flag_o));
  c_err:    cover property ($rose(exec_error_flag_o));
endmodule

bind rdiu_unit rdiu_unit_chk u_chk (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .start_i(start_i), .op_i(op_i), .dtype_i(dtype_i),
  .flag_clear_i(flag_clear_i), .busy_o(busy_o), .done_o(done_o),
  .carry_borrow_flag_o(carry_borrow_flag_o), .exec_error_flag_o(exec_error_flag_o),
  .err_led_o(err_led_o)
);
`default_nettype wire

// ### verif/test_repeat_divide_and_incdec_unit.sv
// Self-checking testbench of the repeat divide and increment/decrement unit
`timescale 1ns/10ps
`default_nettype none
module test_repeat_divide_and_incdec_unit;
  import rdiu_pkg::*;
  logic        clk_i, rst_b_i, start_i, s1_rep, s2_rep, t_rep, host_we_i, flag_clear_i;
  rdiu_op_t    op_i;
  rdiu_dtype_t dtype_i;
  logic [9:0]  s1, s2, tgt, host_addr_i, host_raddr_i;
  logic [4:0]  rep;
  logic [15:0] host_wdata_i, host_rdata_o;
  logic        busy_o, done_o, carry_borrow_flag_o, exec_error_flag_o, err_led_o;
  int          bad_count, samples_checked, cnt, n, i;

  rdiu_unit uut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .start_i(start_i), .op_i(op_i), .dtype_i(dtype_i),
    .first_source_i(s1), .second_source_i(s2), .result_target_i(tgt),
    .repeat_cycles_i(rep), .first_source_rep_i(s1_rep), .second_source_rep_i(s2_rep),
    .result_target_rep_i(t_rep), .host_we_i(host_we_i), .host_addr_i(host_addr_i),
    .host_wdata_i(host_wdata_i), .host_raddr_i(host_raddr_i), .flag_clear_i(flag_clear_i),
    .host_rdata_o(host_rdata_o), .busy_o(busy_o), .done_o(done_o),
    .carry_borrow_flag_o(carry_borrow_flag_o), .exec_error_flag_o(exec_error_flag_o),
    .err_led_o(err_led_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    tick;
    host_we_i = 1'b1;
    host_addr_i = a;
    host_wdata_i = d;
    tick;
    host_we_i = 1'b0;
  endtask

  task automatic ck(input logic [9:0] a, input logic [15:0] e, input string nm);
    tick;
    host_raddr_i = a;
    tick;
    chk(nm, host_rdata_o, e);
  endtask

  task automatic flag(input string nm, input logic seen, input logic exp);
    chk(nm, {15'h0000, seen}, {15'h0000, exp});
  endtask

  task automatic clr;
    tick;
    flag_clear_i = 1'b1;
    tick;
    flag_clear_i = 1'b0;
  endtask

  task automatic run(input rdiu_op_t o, input rdiu_dtype_t d, input logic [9:0] a1, a2, t,
                     input logic [4:0] r, input logic p1, p2, pt);
    int k;
    tick;
    op_i = o;
    dtype_i = d;
    {s1, s2, tgt, rep, s1_rep, s2_rep, t_rep} = {a1, a2, t, r, p1, p2, pt};
    start_i = 1'b1;
    tick;
    start_i = 1'b0;
    k = 0;
    while (done_o !== 1'b1 && k < 2000) begin
      tick;
      k++;
    end
    flag("busy_at_done", busy_o, 1'b0);
    if (k >= 2000) begin
      bad_count++;
      $display("mismatch done_wait expected 1 seen %b", done_o);
      results;
    end
  endtask

  // 32-bit operand at 100/101: upper word at the lower address
  task automatic incdec(input rdiu_op_t o, input rdiu_dtype_t d, input logic [15:0] h, l,
                        input logic [15:0] eh, el, input logic ec);
    wr(10'h064, h);
    wr(10'h065, l);
    clr;
    run(o, d, 10'h000, 10'h000, 10'h064, 5'h01, 1'b0, 1'b0, 1'b0);
    ck(10'h064, eh, "incdec_upper");
    ck(10'h065, el, "incdec_lower");
    flag("incdec_carry", carry_borrow_flag_o, ec);
  endtask

  initial begin
    {start_i, s1_rep, s2_rep, t_rep, host_we_i, flag_clear_i, rst_b_i} = 7'h00;
    {s1, s2, tgt, host_addr_i, host_raddr_i, rep, host_wdata_i} = '0;
    op_i = RDIU_OP_INC;
    dtype_i = RDIU_DT_WORD;
    bad_count = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    flag("reset_carry", carry_borrow_flag_o, 1'b0);
    flag("reset_error", exec_error_flag_o, 1'b0);

    incdec(RDIU_OP_INC, RDIU_DT_WORD, 16'h0005, 16'hAAAA, 16'h0006, 16'hAAAA, 1'b0);
    incdec(RDIU_OP_INC, RDIU_DT_WORD, 16'hFFFF, 16'hAAAA, 16'h0000, 16'hAAAA, 1'b1);
    incdec(RDIU_OP_DEC, RDIU_DT_WORD, 16'h0000, 16'hAAAA, 16'hFFFF, 16'hAAAA, 1'b1);
    incdec(RDIU_OP_DEC, RDIU_DT_INT, 16'h0003, 16'hAAAA, 16'h0002, 16'hAAAA, 1'b0);
    incdec(RDIU_OP_INC, RDIU_DT_DWORD, 16'h0000, 16'hFFFF, 16'h0001, 16'h0000, 1'b0);
    incdec(RDIU_OP_INC, RDIU_DT_DWORD, 16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000, 1'b1);
    incdec(RDIU_OP_DEC, RDIU_DT_LONG, 16'h0001, 16'h0000, 16'h0000, 16'hFFFF, 1'b0);
    incdec(RDIU_OP_DEC, RDIU_DT_DWORD, 16'h0000, 16'h0000, 16'hFFFF, 16'hFFFF, 1'b1);
    incdec(RDIU_OP_INC, RDIU_DT_FLOAT, 16'h1234, 16'h0000, 16'h1234, 16'h0000, 1'b0);
    flag("float_incdec_error", exec_error_flag_o, 1'b1);
    $display("test inc_dec finished");

    // Level start: each done is followed by another pass while the input stays on
    wr(10'h064, 16'h0000);
    tick;
    op_i = RDIU_OP_INC;
    dtype_i = RDIU_DT_WORD;
    tgt = 10'h064;
    start_i = 1'b1;
    cnt = 0;
    n = 0;
    while (cnt < 3 && n < 100) begin
      tick;
      n++;
      if (done_o === 1'b1) cnt++;
    end
    start_i = 1'b0;
    flag("level_start_timeout", n >= 100, 1'b0);
    ck(10'h064, 16'h0003, "level_start_count");
    $display("test level_start finished");

    for (i = 300; i < 640; i++) wr(i[9:0], 16'h5A5A);
    wr(10'h0C8, 16'h0064);
    wr(10'h0C9, 16'h0011);
    wr(10'h0CA, 16'h0009);
    wr(10'h0D2, 16'h0007);
    run(RDIU_OP_DIV, RDIU_DT_WORD, 10'h0C8, 10'h0D2, 10'd300, 5'h03, 1'b1, 1'b0, 1'b1);
    ck(10'd300, 16'h000E, "q0");
    ck(10'd301, 16'h0002, "q1");
    ck(10'd302, 16'h0001, "q2");
    ck(10'd303, 16'h0002, "r0");
    ck(10'd304, 16'h0003, "r1");
    ck(10'd305, 16'h0002, "r2");
    ck(10'd306, 16'h5A5A, "past_rem_block");
    run(RDIU_OP_DIV, RDIU_DT_INT, 10'h0C8, 10'h0D2, 10'd320, 5'h03, 1'b1, 1'b0, 1'b0);
    ck(10'd320, 16'h0001, "fixed_q");
    ck(10'd321, 16'h0002, "fixed_r");
    ck(10'd322, 16'h5A5A, "fixed_past");
    wr(10'h0C8, 16'hFF9C); // -100 over 7
    run(RDIU_OP_DIV, RDIU_DT_INT, 10'h0C8, 10'h0D2, 10'd340, 5'h01, 1'b0, 1'b0, 1'b0);
    ck(10'd340, 16'hFFF2, "neg_q");
    ck(10'd341, 16'hFFFE, "neg_r");
    $display("test div_word finished");

    wr(10'd400, 16'h0001); // 65536 then 100, over 3 then 7
    wr(10'd401, 16'h0000);
    wr(10'd402, 16'h0000);
    wr(10'd403, 16'h0064);
    wr(10'd410, 16'h0000);
    wr(10'd411, 16'h0003);
    wr(10'd412, 16'h0000);
    wr(10'd413, 16'h0007);
    run(RDIU_OP_DIV, RDIU_DT_DWORD, 10'd400, 10'd410, 10'd500, 5'h02, 1'b0, 1'b0, 1'b1);
    for (i = 0; i < 2; i++) begin
      ck(10'(500 + 2 * i), 16'h0000, "dq_hi");
      ck(10'(501 + 2 * i), 16'h5555, "dq_lo");
      ck(10'(504 + 2 * i), 16'h0000, "dr_hi");
      ck(10'(505 + 2 * i), 16'h0001, "dr_lo");
    end
    ck(10'd508, 16'h5A5A, "dpast");
    run(RDIU_OP_DIV, RDIU_DT_LONG, 10'd400, 10'd410, 10'd520, 5'h02, 1'b1, 1'b1, 1'b0);
    ck(10'd520, 16'h0000, "lq_hi");
    ck(10'd521, 16'h000E, "lq_lo");
    ck(10'd522, 16'h0000, "lr_hi");
    ck(10'd523, 16'h0002, "lr_lo");
    $display("test div_wide finished");

    wr(10'd600, 16'h40C0); // 6.0 over 2.0
    wr(10'd601, 16'h0000);
    wr(10'd610, 16'h4000);
    wr(10'd611, 16'h0000);
    run(RDIU_OP_DIV, RDIU_DT_FLOAT, 10'd600, 10'd610, 10'd620, 5'h02, 1'b0, 1'b0, 1'b1);
    for (i = 0; i < 2; i++) begin
      ck(10'(620 + 2 * i), 16'h4040, "fq_hi");
      ck(10'(621 + 2 * i), 16'h0000, "fq_lo");
    end
    ck(10'd624, 16'h5A5A, "no_float_rem");
    $display("test div_float finished");

    clr;
    wr(10'h0D3, 16'h0000);
    run(RDIU_OP_DIV, RDIU_DT_WORD, 10'h0C8, 10'h0D3, 10'd330, 5'h01, 1'b0, 1'b0, 1'b0);
    ck(10'd330, 16'h5A5A, "zero_div_unwritten");
    flag("zero_div_error", exec_error_flag_o, 1'b1);
    flag("zero_div_led", err_led_o, 1'b1);
    run(RDIU_OP_INC, RDIU_DT_WORD, 10'h000, 10'h000, 10'h064, 5'h01, 1'b0, 1'b0, 1'b0);
    ck(10'h064, 16'h0004, "after_error_inc");
    flag("error_held", exec_error_flag_o, 1'b1);
    clr;
    flag("error_cleared", exec_error_flag_o, 1'b0);
    $display("test div_error finished");
    results;
  end
endmodule
`default_nettype wire
